// [design/pf_fabric.sv]
`timescale 1ns/10ps
// Notes on behaviour
// - all io pins and two dedicated inputs enter the routing matrix for four blocks
// - four clock pins, each also usable as a plain logic input
// - each block: sixty-four term array, allocator, sixteen macrocells, sixteen io cells
// - routing matrix hands exactly twenty-six inputs to each block
// - six extra terms per block: four enables, one reset, one preset
// - io cells split into two banks of eight, each bank owning two enable terms
// - block reset or preset term sets every flip-flop at once, no clock needed
// - each block returns sixteen macrocell and sixteen pin feedbacks to the matrix
// - allocator shares sixty-four terms; one macrocell sums at most twelve
// - macrocell n uses clusters n-1, n, n+1 only, where they exist
// - macrocell registered or combinational, output polarity selectable
// - macrocell feeds back its result in either configuration
// - flip-flop acts as d-type or t-type
// - each flip-flop picks one of the four global clock pins
// - flip-flops capture on rising edge of the selected clock
// - driver mode: always on, always off, or gated by a term
// - gated cells pick one of their bank's two enable terms
// - a buried macrocell leaves its pin usable as a matrix input
// - modes give output, input, bidirectional and bus three-state pins
module pf_fabric #(
   parameter int NUM_BLOCKS = pf_pkg::NUM_BLOCKS,
   parameter int BLK_INPUTS = pf_pkg::BLK_INPUTS,
   parameter int NUM_MC = pf_pkg::NUM_MC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [pf_pkg::NUM_IO-1:0] io_in,
   output logic [pf_pkg::NUM_IO-1:0] io_out,
   output logic [pf_pkg::NUM_IO-1:0] io_oe_n,
   input wire logic [pf_pkg::NUM_DED-1:0] ded_in,
   input wire logic [pf_pkg::NUM_GCLK-1:0] gclk_in
);

   localparam int NB = pf_pkg::NUM_BLOCKS;
   localparam int NT = pf_pkg::TOTAL_TERMS;
   localparam int NI = pf_pkg::BLK_INPUTS;
   localparam int NM = pf_pkg::NUM_MC;
   localparam int NG = NB * NM;

   generate
      if (NUM_BLOCKS != NB || BLK_INPUTS != NI || NUM_MC != NM)
      begin : g_bad_param
         $error("pf_fabric: dimensions must match the register layout");
      end
   endgenerate

   // configuration store
   logic [NI-1:0] term_true [NB][NT];
   logic [NI-1:0] term_comp [NB][NT];
   pf_pkg::pf_mc_cfg_s mc_cfg [NB][NM];
   logic [pf_pkg::SRC_SEL_W-1:0] route [NB][NI];

   // fabric state
   logic [NG-1:0] mc_q;
   logic [NG-1:0] fb_q;
   logic [pf_pkg::NUM_GCLK-1:0] gclk_prev;

   // evaluation nets
   logic [pf_pkg::NUM_SRC-1:0] src;
   logic [NI-1:0] blk_in [NB];
   logic [NT-1:0] terms [NB];
   logic [NG-1:0] mc_sum;
   logic [NG-1:0] mc_state;
   logic [NG-1:0] mc_val;
   logic [NG-1:0] mc_drive;
   logic [pf_pkg::NUM_GCLK-1:0] gclk_rise;
   logic [NB-1:0] blk_areset;
   logic [NB-1:0] blk_apreset;

   // bus state
   logic dp_valid;
   logic dp_write;
   logic rd_done;
   logic [pf_pkg::ADDR_W-1:0] dp_addr;
   logic [31:0] next_rdata;
   logic take;
   logic wr_en;
   logic [1:0] dp_region;
   logic [1:0] dp_block;
   logic [6:0] dp_term;
   logic [3:0] dp_mc;
   logic [4:0] dp_route;
   logic dp_block_ok;

   // AHB-Lite slave
   assign take = hsel & hready & htrans[1];
   assign hresp = pf_pkg::HRESP_OKAY;
   // reads take one wait state so hrdata comes from a flop
   assign hreadyout = ~(dp_valid & ~dp_write & ~rd_done);
   assign wr_en = dp_valid & dp_write;
   assign dp_region = dp_addr[pf_pkg::REGION_LSB +: 2];
   assign dp_block = dp_addr[pf_pkg::BLOCK_LSB +: 2];
   assign dp_term = dp_addr[pf_pkg::TERM_LSB +: 7];
   assign dp_mc = dp_addr[pf_pkg::WORD_LSB +: 4];
   assign dp_route = dp_addr[pf_pkg::WORD_LSB +: 5];
   assign dp_block_ok = 32'(dp_block) < NB;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= '0;
      end
      else if (hready)
      begin
         dp_valid <= take;
         if (take)
         begin
            dp_write <= hwrite;
            dp_addr <= haddr[pf_pkg::ADDR_W-1:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         rd_done <= 1'b0;
      else
         rd_done <= dp_valid & ~dp_write & ~rd_done;

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (dp_valid & ~dp_write & ~rd_done)
         hrdata <= next_rdata;

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      case (dp_region)
         pf_pkg::REGION_TERM:
         begin
            if (dp_block_ok && 32'(dp_term) < NT)
            begin
               if (dp_addr[pf_pkg::MASK_SEL_BIT])
               begin
                  next_rdata[NI-1:0] = term_comp[dp_block][dp_term];
               end
               else
               begin
                  next_rdata[NI-1:0] = term_true[dp_block][dp_term];
               end
            end
         end
         pf_pkg::REGION_MC:
         begin
            if (dp_block_ok)
            begin
               next_rdata[pf_pkg::MC_CFG_W-1:0] = mc_cfg[dp_block][dp_mc];
            end
         end
         pf_pkg::REGION_ROUTE:
         begin
            if (dp_block_ok && 32'(dp_route) < NI)
            begin
               next_rdata[pf_pkg::SRC_SEL_W-1:0] = route[dp_block][dp_route];
            end
         end
         pf_pkg::REGION_STATUS:
         begin
            case (dp_addr[pf_pkg::WORD_LSB +: 2])
               pf_pkg::STATUS_IO_LO: next_rdata = io_in[31:0];
               pf_pkg::STATUS_IO_HI: next_rdata = io_in[63:32];
               pf_pkg::STATUS_FB_LO: next_rdata = fb_q[31:0];
               pf_pkg::STATUS_FB_HI: next_rdata = fb_q[63:32];
               default: next_rdata = 32'h0000_0000;
            endcase
         end
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // product term masks
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int b = 0; b < NB; b++)
         begin
            for (int t = 0; t < NT; t++)
            begin
               term_true[b][t] <= pf_pkg::TERM_MASK_RESET;
               term_comp[b][t] <= pf_pkg::TERM_MASK_RESET;
            end
         end
      end
      else if (wr_en && dp_region == pf_pkg::REGION_TERM && dp_block_ok
               && 32'(dp_term) < NT)
      begin
         if (dp_addr[pf_pkg::MASK_SEL_BIT])
            term_comp[dp_block][dp_term] <= hwdata[NI-1:0];
         else
            term_true[dp_block][dp_term] <= hwdata[NI-1:0];
      end
   end

   // macrocell and io cell configuration
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int b = 0; b < NB; b++)
         begin
            for (int m = 0; m < NM; m++)
            begin
               mc_cfg[b][m] <= pf_pkg::MC_CFG_RESET;
            end
         end
      end
      else if (wr_en && dp_region == pf_pkg::REGION_MC && dp_block_ok)
      begin
         mc_cfg[dp_block][dp_mc] <= hwdata[pf_pkg::MC_CFG_W-1:0];
      end
   end

   // routing matrix selections
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int b = 0; b < NB; b++)
         begin
            for (int k = 0; k < NI; k++)
            begin
               route[b][k] <= pf_pkg::ROUTE_RESET;
            end
         end
      end
      else if (wr_en && dp_region == pf_pkg::REGION_ROUTE && dp_block_ok
               && 32'(dp_route) < NI)
      begin
         route[dp_block][dp_route] <= hwdata[pf_pkg::SRC_SEL_W-1:0];
      end
   end

   // matrix sources: pins, dedicated inputs, clock pins, feedback
   assign src = {fb_q, gclk_in, ded_in, io_in};

   always_comb
   begin
      for (int b = 0; b < NB; b++)
      begin
         for (int k = 0; k < NI; k++)
         begin
            if (32'(route[b][k]) < pf_pkg::NUM_SRC)
               blk_in[b][k] = src[route[b][k]];
            else
               blk_in[b][k] = 1'b0;
         end
      end
   end

   // unprogrammed term (no literal) is false
   always_comb
   begin
      for (int b = 0; b < NB; b++)
      begin
         for (int t = 0; t < NT; t++)
         begin
            terms[b][t] = (|(term_true[b][t] | term_comp[b][t]))
                        & (&(~term_true[b][t] | blk_in[b]))
                        & (&(~term_comp[b][t] | ~blk_in[b]));
         end
         blk_areset[b] = terms[b][pf_pkg::TERM_ARESET];
         blk_apreset[b] = terms[b][pf_pkg::TERM_APRESET];
      end
   end

   // allocator: bit j of alloc takes term 4*(m-1)+j
   always_comb
   begin
      int idx;
      idx = 0;
      for (int b = 0; b < NB; b++)
      begin
         for (int m = 0; m < NM; m++)
         begin
            mc_sum[b*NM+m] = 1'b0;
            for (int j = 0; j < pf_pkg::ALLOC_WIDTH; j++)
            begin
               idx = (m - 1) * pf_pkg::TERMS_PER_CLUSTER + j;
               if (idx >= 0 && idx < pf_pkg::LOGIC_TERMS)
               begin
                  mc_sum[b*NM+m] = mc_sum[b*NM+m]
                                 | (mc_cfg[b][m].alloc[j] & terms[b][idx]);
               end
            end
         end
      end
   end

   assign gclk_rise = gclk_in & ~gclk_prev;

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         gclk_prev <= '0;
      else
         gclk_prev <= gclk_in;

   // macrocell flip-flops
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mc_q <= '0;
      end
      else
      begin
         for (int b = 0; b < NB; b++)
         begin
            for (int m = 0; m < NM; m++)
            begin
               if (blk_areset[b])
                  mc_q[b*NM+m] <= 1'b0;
               else if (blk_apreset[b])
                  mc_q[b*NM+m] <= 1'b1;
               else if (gclk_rise[mc_cfg[b][m].clk_sel])
               begin
                  if (mc_cfg[b][m].t_type)
                     mc_q[b*NM+m] <= mc_q[b*NM+m] ^ mc_sum[b*NM+m];
                  else
                     mc_q[b*NM+m] <= mc_sum[b*NM+m];
               end
            end
         end
      end
   end

   // outputs, polarity and driver enables
   always_comb
   begin
      for (int b = 0; b < NB; b++)
      begin
         for (int m = 0; m < NM; m++)
         begin
            // init terms act without waiting for a clock
            if (blk_areset[b])
               mc_state[b*NM+m] = 1'b0;
            else if (blk_apreset[b])
               mc_state[b*NM+m] = 1'b1;
            else
               mc_state[b*NM+m] = mc_q[b*NM+m];
            mc_val[b*NM+m] = (mc_cfg[b][m].registered ? mc_state[b*NM+m]
                             : mc_sum[b*NM+m]) ^ mc_cfg[b][m].invert;
            case (mc_cfg[b][m].oe_mode)
               pf_pkg::PF_OE_ON: mc_drive[b*NM+m] = 1'b1;
               pf_pkg::PF_OE_TERM: mc_drive[b*NM+m] = terms[b][pf_pkg::TERM_OE_BASE
                  + (m / pf_pkg::BANK_SIZE) * 2 + 32'(mc_cfg[b][m].oe_sel)];
               default: mc_drive[b*NM+m] = 1'b0;
            endcase
         end
      end
   end

   // feedback sampled each hclk, breaking combinational loops
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         fb_q <= '0;
      else
         fb_q <= mc_val;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         io_out <= '0;
         io_oe_n <= '1;
      end
      else
      begin
         io_out <= mc_val;
         io_oe_n <= ~mc_drive;
      end
   end

endmodule // pf_fabric

// [design/pf_pkg.sv]
package pf_pkg;
   // fabric dimensions
   localparam int NUM_BLOCKS = 4;
   localparam int NUM_IO = 64;
   localparam int NUM_DED = 2;
   localparam int NUM_GCLK = 4;
   localparam int BLK_INPUTS = 26;
   localparam int LOGIC_TERMS = 64;
   localparam int SPECIAL_TERMS = 6;
   localparam int TOTAL_TERMS = LOGIC_TERMS + SPECIAL_TERMS;
   localparam int NUM_MC = 16;
   localparam int BANK_SIZE = 8;
   localparam int TERMS_PER_CLUSTER = 4;
   localparam int ALLOC_WIDTH = 12;
   localparam int SRC_SEL_W = 8;
   // special term indices within a block
   localparam int TERM_OE_BASE = 64;
   localparam int TERM_ARESET = 68;
   localparam int TERM_APRESET = 69;
   // routing source layout
   localparam int SRC_IO = 0;
   localparam int SRC_DED = SRC_IO + NUM_IO;
   localparam int SRC_GCLK = SRC_DED + NUM_DED;
   localparam int SRC_FB = SRC_GCLK + NUM_GCLK;
   localparam int NUM_SRC = SRC_FB + NUM_BLOCKS * NUM_MC;
   // byte address layout
   localparam int REGION_LSB = 13;
   localparam int BLOCK_LSB = 10;
   localparam int TERM_LSB = 3;
   localparam int MASK_SEL_BIT = 2;
   localparam int WORD_LSB = 2;
   localparam int ADDR_W = 15;
   localparam logic [1:0] REGION_TERM = 2'h0;
   localparam logic [1:0] REGION_MC = 2'h1;
   localparam logic [1:0] REGION_ROUTE = 2'h2;
   localparam logic [1:0] REGION_STATUS = 2'h3;
   localparam logic [1:0] STATUS_IO_LO = 2'h0;
   localparam logic [1:0] STATUS_IO_HI = 2'h1;
   localparam logic [1:0] STATUS_FB_LO = 2'h2;
   localparam logic [1:0] STATUS_FB_HI = 2'h3;
   // output enable modes
   typedef enum logic [1:0] {
      PF_OE_OFF,
      PF_OE_ON,
      PF_OE_TERM,
      PF_OE_RSVD
   } pf_oe_mode_e;
   // macrocell configuration word, alloc in bits 11:0
   typedef struct packed {
      logic oe_sel;
      pf_oe_mode_e oe_mode;
      logic [1:0] clk_sel;
      logic t_type;
      logic invert;
      logic registered;
      logic [ALLOC_WIDTH-1:0] alloc;
   } pf_mc_cfg_s;
   localparam int MC_CFG_W = $bits(pf_mc_cfg_s);
   localparam pf_mc_cfg_s MC_CFG_RESET = '0;
   localparam logic [BLK_INPUTS-1:0] TERM_MASK_RESET = '0;
   localparam logic [SRC_SEL_W-1:0] ROUTE_RESET = 8'h00;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;
endpackage

// [tb/pf_fabric_assertions.sv]
`timescale 1ns/10ps
module pf_fabric_assertions (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [pf_pkg::NUM_IO-1:0] io_out,
   input wire logic [pf_pkg::NUM_IO-1:0] io_oe_n
);
   logic take;
   logic rd_take;
   logic wrote;
   logic rd_seen;
   assign take = hsel && hready && htrans[1];
   assign rd_take = take && !hwrite;
   // remembers whether any write or read has been taken since reset
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         wrote <= 1'b0;
         rd_seen <= 1'b0;
      end
      else if (take)
      begin
         wrote <= wrote | hwrite;
         rd_seen <= rd_seen | !hwrite;
      end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   okay_resp_a: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   read_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
      else $error("read data phase not one wait state");
   write_nowait_a: assert property (take && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   wait_cause_a: assert property (!hreadyout |-> $past(rd_take))
      else $error("wait state without a read");
   ready_back_a: assert property ($fell(hreadyout) |=> $rose(hreadyout))
      else $error("ready low for more than one cycle");
   rdata_hold_a: assert property (!$stable(hrdata) |-> !$past(hreadyout))
      else $error("read data changed outside a read");
   rdata_clear_a: assert property (!rd_seen |-> hrdata == 32'h0)
      else $error("read data not zero before any read");
   pins_idle_a: assert property (!wrote |-> io_oe_n == '1 && io_out == '0)
      else $error("pins active before any configuration");
endmodule // pf_fabric_assertions

// [tb/pf_board.sv]
`timescale 1ns/10ps
module pf_board (
   input wire logic [pf_pkg::NUM_IO-1:0] io_out,
   input wire logic [pf_pkg::NUM_IO-1:0] io_oe_n,
   input wire logic [pf_pkg::NUM_IO-1:0] drive_val,
   output logic [pf_pkg::NUM_IO-1:0] io_in
);
   // a pin the device drives shows its level, else the board level
   always_comb
      for (int i = 0; i < pf_pkg::NUM_IO; i++)
         io_in[i] = io_oe_n[i] ? drive_val[i] : io_out[i];
endmodule // pf_board

// [tb/tb_programmable_logic_block_fabric.sv]
`timescale 1ns/10ps
module tb_programmable_logic_block_fabric;
   logic hclk, hresetn, hsel, hwrite, rd_ph, hreadyout, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, lfsr, v, ex;
   logic [63:0] io_in, io_out, io_oe_n, board_val;
   logic [1:0] ded_in;
   logic [3:0] gclk_in;
   logic [31:0] exp_q[$];
   int miscompares = 0;
   int samples_checked = 0;
   int cyc = 0;
   pf_fabric dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .ded_in(ded_in),
      .gclk_in(gclk_in));
   pf_board board_u (.io_out(io_out), .io_oe_n(io_oe_n), .drive_val(board_val),
      .io_in(io_in));
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   function automatic logic [31:0] ta(input int b, input int t, input int s);
      return 32'(b * 1024 + t * 8 + s * 4);
   endfunction
   function automatic logic [31:0] ma(input int b, input int m);
      return 32'(32'h2000 + b * 1024 + m * 4);
   endfunction
   function automatic logic [31:0] ra(input int b, input int k);
      return 32'(32'h4000 + b * 1024 + k * 4);
   endfunction
   task automatic report_and_stop();
      $display("checked %0d miscompares %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      samples_checked++;
      if (got !== want)
      begin
         miscompares++;
         $display("FAIL %0t got %h expected %h", $time, got, want);
      end
   endtask
   // ready sampled at the rising edge; every change follows that edge
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      htrans <= pf_pkg::HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      rd_ph <= !wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_ph <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic settle();
      repeat (3) @(posedge hclk);
      @(negedge hclk);
   endtask
   task automatic setd(input logic [1:0] d, input logic p3);
      @(posedge hclk);
      ded_in <= d;
      board_val <= {60'h0, p3, 3'h0};
      settle();
   endtask
   task automatic tick(input int c);
      @(posedge hclk);
      gclk_in[c] <= 1'b1;
      settle();
      @(posedge hclk);
      gclk_in[c] <= 1'b0;
      settle();
   endtask
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         report_and_stop();
      end
   end
   // read data taken where ready is high in a read data phase
   always @(posedge hclk)
      if (rd_ph && hreadyout === 1'b1)
         chk(hrdata, exp_q.pop_front());
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b1;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      rd_ph = 1'b0;
      board_val = '0;
      ded_in = 2'h0;
      gclk_in = 4'h0;
      lfsr = 32'h9;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rd(ta(1, 5, 1), 32'h0);
      rd(ma(3, 15), 32'h0);
      rd(ra(2, 25), 32'h0);
      bus(1'b1, ta(0, 70, 0), 32'hffffffff);
      rd(ta(0, 70, 0), 32'h0);
      bus(1'b1, ra(0, 26), 32'hff);
      rd(ra(0, 26), 32'h0);
      v = rnd();
      @(posedge hclk);
      board_val <= {~v, v};
      rd(32'h6000, v);
      rd(32'h6004, ~v);
      for (int i = 0; i < 4; i++)
      begin
         v = rnd();
         bus(1'b1, ma(i, i * 5), v);
         rd(ma(i, i * 5), v & 32'h000fffff);
         bus(1'b1, ma(i, i * 5), 32'h0);
         bus(1'b1, ta(i, 60 + i, i % 2), v);
         rd(ta(i, 60 + i, i % 2), v & 32'h03ffffff);
         bus(1'b1, ra(i, 25), v);
         rd(ra(i, 25), v & 32'h000000ff);
      end
      // literals: dedicated inputs and pin 3; term0 sum, reset and preset terms
      bus(1'b1, ra(0, 0), 32'd64);
      bus(1'b1, ra(0, 1), 32'd65);
      bus(1'b1, ra(0, 2), 32'd3);
      bus(1'b1, ta(0, 0, 0), 32'h1);
      bus(1'b1, ta(0, 68, 0), 32'h2);
      bus(1'b1, ta(0, 69, 0), 32'h4);
      for (int c = 0; c < 4; c++)
      begin
         bus(1'b1, ma(0, 0), 32'h21010 | (c << 15));
         setd(2'b01, 1'b0);
         tick(c ^ 1);
         chk(32'(io_out[0]), 32'h0);
         tick(c);
         chk(32'(io_out[0]), 32'h1);
         chk(32'(io_oe_n[0]), 32'h0);
         rd(32'h6008, 32'h1);
         setd(2'b00, 1'b0);
         tick(c);
         chk(32'(io_out[0]), 32'h0);
      end
      bus(1'b1, ma(0, 0), 32'h25010);
      for (int k = 0; k < 3; k++)
      begin
         setd({1'b0, k != 1}, 1'b0);
         tick(0);
         chk(32'(io_out[0]), 32'(k < 2));
      end
      bus(1'b1, ma(0, 0), 32'h21010);
      bus(1'b1, ma(0, 1), 32'h21001);
      for (int k = 0; k < 5; k++)
      begin
         setd({k / 2 == 1, 1'b0}, k % 2 == 0);
         chk(32'({io_out[1], io_out[0]}), (k / 2 == 1) ? 32'h0 : 32'h3);
      end
      for (int k = 0; k < 4; k++)
      begin
         bus(1'b1, ma(0, 0), 32'h20010 | ((k / 2) << 13));
         setd(2'(k % 2), 1'b0);
         chk(32'(io_out[0]), 32'((k % 2) ^ (k / 2)));
      end
      bus(1'b1, ta(0, 64, 0), 32'h1);
      bus(1'b1, ta(0, 66, 0), 32'h1);
      for (int k = 0; k < 16; k++)
      begin
         v = 32'(((k % 4) << 17) | ((k / 4 % 2) << 19));
         bus(1'b1, ma(0, 0), v);
         bus(1'b1, ma(0, 8), v);
         setd(2'(k / 8), 1'b0);
         ex = (k % 4 == 1 || (k % 4 == 2 && k / 4 % 2 == 0 && k / 8 == 1)) ? 0 : 3;
         chk(32'({io_oe_n[8], io_oe_n[0]}), ex);
      end
      bus(1'b1, ta(0, 66, 0), 32'h0);
      bus(1'b1, ma(0, 0), 32'h40000);
      bus(1'b1, ma(0, 8), 32'h40000);
      settle();
      chk(32'({io_oe_n[8], io_oe_n[0]}), 32'h2);
      // clock pin 0 used as a plain logic input of a combinational cell
      bus(1'b1, ra(0, 0), 32'd66);
      bus(1'b1, ma(0, 0), 32'h20010);
      for (int k = 0; k < 2; k++)
      begin
         @(posedge hclk);
         gclk_in[0] <= 1'(k);
         settle();
         chk(32'(io_out[0]), 32'(k));
      end
      report_and_stop();
   end
endmodule // tb_programmable_logic_block_fabric
bind pf_fabric pf_fabric_assertions chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .io_out(io_out), .io_oe_n(io_oe_n));
